//--- include/msc_defs.svh
// Purpose: constants of the motion status/control register bank
// Assumes: byte-wide register port, 12-bit address
// Notes:   offsets are byte addresses on the plain register port
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_AW            12
`define MSC_DW            8
`define MSC_SW            10

`define MSC_OFF_ENABLE    12'h100
`define MSC_OFF_CTRL      12'h102
`define MSC_OFF_RANGE     12'h104
`define MSC_OFF_IRQ_STS   12'h110
`define MSC_OFF_IRQ_MASK  12'h111

`define MSC_ON_CODE       8'h11
`define MSC_OFF_CODE      8'h00

`define MSC_B_LVL_HI      7
`define MSC_B_LVL_LO      6
`define MSC_B_ACK         5
`define MSC_B_PAUSE       4
`define MSC_B_DIR_EN      3
`define MSC_B_DIR         2
`define MSC_B_DET         1
`define MSC_B_STABLE      0

`define MSC_RANGE_W       3
`define MSC_RANGE_RST     3'h0
`define MSC_EN_RST        8'h00
`define MSC_BASE_THR      10'h040

`define MSC_IRQ_W         3
`define MSC_IRQ_DET       0
`define MSC_IRQ_STABLE    1
`define MSC_IRQ_STOP      2

`define MSC_TRK_SHIFT     4
`define MSC_TRK_TOL       10'h008
`define MSC_TRK_COUNT     64

`endif

//--- include/msc_pkg.sv
// Purpose: types of the motion status/control register bank
// Assumes: msc_defs.svh on the include path
// Notes:   none
`default_nettype none
`include "msc_defs.svh"

package msc_pkg;

	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic [`MSC_AW-1:0]   addr;
		logic [`MSC_DW-1:0]   wdata;
	} msc_bus_req_t;

	typedef struct packed {
		logic                 valid;
		logic [`MSC_SW-1:0]   data;
	} msc_sample_t;

	typedef enum logic [1:0] {
		MSC_ST_OFF  = 2'h0,
		MSC_ST_INIT = 2'h1,
		MSC_ST_ON   = 2'h3
	} msc_state_t;

endpackage : msc_pkg

`default_nettype wire

//--- verilog/msc_offset_tracker.sv
// Purpose: follows the DC offset of the sensor samples and judges it settled
// Assumes: one sample per valid pulse, same clock as the register bank
// Notes:   restart drops the settled flag and reloads the baseline
`default_nettype none
`include "msc_defs.svh"

module msc_offset_tracker
	import msc_pkg::*;
#(
	parameter int SHIFT = `MSC_TRK_SHIFT,
	parameter int COUNT = `MSC_TRK_COUNT
) (
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire logic               restart,
	input  wire msc_sample_t        sample,
	output logic [`MSC_SW-1:0]      baseline,
	output logic                    stable
);

	logic [`MSC_SW-1:0] base_r;
	logic               loaded_r;
	logic               stable_r;
	logic [7:0]         cnt_r;

	wire logic signed [`MSC_SW:0] diff  = $signed({1'b0, sample.data}) - $signed({1'b0, base_r});
	wire logic signed [`MSC_SW:0] step  = diff >>> SHIFT;
	wire logic [`MSC_SW:0]        mag   = diff[`MSC_SW] ? (~diff + 11'h001) : diff;
	wire logic                    quiet = mag <= {1'b0, `MSC_TRK_TOL};
	wire logic [`MSC_SW:0]        sum   = $signed({1'b0, base_r}) + step;

	// Settled once COUNT quiet samples follow one another
	always_ff @(posedge clock) begin
		if (!rst_n || restart) begin
			base_r   <= '0;
			loaded_r <= 1'b0;
			stable_r <= 1'b0;
			cnt_r    <= '0;
		end else if (sample.valid) begin
			loaded_r <= 1'b1;
			base_r   <= loaded_r ? sum[`MSC_SW-1:0] : sample.data;
			if (!loaded_r || !quiet) begin
				cnt_r <= '0;
			end else if (cnt_r != 8'(COUNT)) begin
				cnt_r <= cnt_r + 8'h01;
			end
			if (loaded_r && quiet && cnt_r == 8'(COUNT - 1)) begin
				stable_r <= 1'b1;
			end
		end
	end

	assign baseline = base_r;
	assign stable   = stable_r;

endmodule : msc_offset_tracker

`default_nettype wire

//--- verilog/msc_engine.sv
// Purpose: motion status/control register bank of a passive infrared detection engine
// Assumes: conversion results arrive as one-cycle pulses on the register bank clock
// Notes:   detection is a plain amplitude check against the tracked offset
`default_nettype none
`include "msc_defs.svh"

module msc_engine
	import msc_pkg::*;
#(
	parameter int TRK_SHIFT = `MSC_TRK_SHIFT,
	parameter int TRK_COUNT = `MSC_TRK_COUNT
) (
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire msc_bus_req_t       bus,
	output logic [`MSC_DW-1:0]      rdata,
	input  wire msc_sample_t        sample,
	input  wire logic               wake,
	output logic                    irq
);

	function automatic logic msc_hit(input logic [`MSC_AW-1:0] a, input logic [`MSC_AW-1:0] off);
		msc_hit = (a == off);
	endfunction : msc_hit

	msc_state_t               state_r;
	msc_state_t               state_nxt;
	logic [`MSC_DW-1:0]       en_r;
	logic [1:0]               lvl_r;
	logic                     ack_r;
	logic                     ack_nxt;
	logic                     pause_r;
	logic                     dir_en_r;
	logic                     dir_r;
	logic                     dir_nxt;
	logic                     det_r;
	logic                     det_nxt;
	logic [`MSC_RANGE_W-1:0]  range_r;
	logic [`MSC_SW-1:0]       buf_r;
	logic [`MSC_IRQ_W-1:0]    sts_r;
	logic [`MSC_IRQ_W-1:0]    sts_nxt;
	logic [`MSC_IRQ_W-1:0]    mask_r;
	logic [`MSC_DW-1:0]       rdata_r;
	logic                     irq_r;
	logic                     stable_q_r;

	logic [`MSC_SW-1:0]       baseline;
	logic                     stable;

	// Register decode
	wire logic wr_en     = bus.wr && msc_hit(bus.addr, `MSC_OFF_ENABLE);
	wire logic wr_ctrl   = bus.wr && msc_hit(bus.addr, `MSC_OFF_CTRL);
	wire logic wr_range  = bus.wr && msc_hit(bus.addr, `MSC_OFF_RANGE);
	wire logic wr_sts    = bus.wr && msc_hit(bus.addr, `MSC_OFF_IRQ_STS);
	wire logic wr_mask   = bus.wr && msc_hit(bus.addr, `MSC_OFF_IRQ_MASK);
	wire logic on_wr     = wr_en && bus.wdata == `MSC_ON_CODE;
	wire logic det_clr   = wr_ctrl && !bus.wdata[`MSC_B_DET];

	// Engine sequencing is paced by conversions, except the on code, which enters init at once
	wire logic running   = state_r == MSC_ST_ON;
	wire logic conv      = sample.valid && state_r != MSC_ST_OFF;
	wire logic stop_seen = conv && en_r == `MSC_OFF_CODE;
	wire msc_sample_t trk_sample = '{valid: conv, data: sample.data};

	// Deviation from the tracked offset and its sign
	wire logic signed [`MSC_SW:0] dev  = $signed({1'b0, sample.data}) - $signed({1'b0, baseline});
	wire logic [`MSC_SW:0]        mag  = dev[`MSC_SW] ? (~dev + 11'h001) : dev;
	wire logic                    pos  = !dev[`MSC_SW];

	// Higher level lowers the base threshold and shrinks the range term
	wire logic [1:0]         rshift = 2'h3 - lvl_r;
	wire logic [`MSC_SW-1:0] base_t = `MSC_BASE_THR >> lvl_r;
	wire logic [`MSC_SW-1:0] rng_t  = {7'h00, range_r} << rshift;
	wire logic [`MSC_SW:0]   thr    = {1'b0, base_t} + {1'b0, rng_t};

	// Paused or unsettled conversions never report motion
	wire logic det_set = running && sample.valid && !stop_seen && !pause_r
		&& stable && mag > thr;

	msc_offset_tracker #(
		.SHIFT    (TRK_SHIFT),
		.COUNT    (TRK_COUNT)
	) u_trk (
		.clock    (clock),
		.rst_n    (rst_n),
		.restart  (on_wr || wake),
		.sample   (trk_sample),
		.baseline (baseline),
		.stable   (stable)
	);

	// Engine state and acknowledge
	always_comb begin
		state_nxt = state_r;
		ack_nxt   = ack_r;
		if (on_wr) begin
			state_nxt = MSC_ST_INIT;
		end else if (stop_seen) begin
			state_nxt = MSC_ST_OFF;
			ack_nxt   = 1'b1;
		end else if (conv && state_r == MSC_ST_INIT) begin
			state_nxt = MSC_ST_ON;
			ack_nxt   = 1'b0;
		end
	end

	// Detected flag: engine sets, software clears, set wins
	always_comb begin
		det_nxt = det_r;
		dir_nxt = dir_r;
		if (on_wr) begin
			det_nxt = 1'b0;
			dir_nxt = 1'b0;
		end else begin
			if (det_clr) begin
				det_nxt = 1'b0;
			end
			if (det_set) begin
				det_nxt = 1'b1;
			end
			if (det_set && !det_r) begin
				dir_nxt = dir_en_r ? pos : 1'b0;
			end
		end
	end

	wire logic [`MSC_IRQ_W-1:0] ev = {stop_seen, stable && !stable_q_r, det_set};
	wire logic [`MSC_IRQ_W-1:0] w1c = wr_sts ? bus.wdata[`MSC_IRQ_W-1:0] : '0;

	always_comb begin
		sts_nxt = (sts_r & ~w1c) | ev;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= MSC_ST_OFF;
			ack_r   <= 1'b1;
			det_r   <= 1'b0;
			dir_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ack_r   <= ack_nxt;
			det_r   <= det_nxt;
			dir_r   <= dir_nxt;
		end
	end

	// Software-owned fields; engine-owned bits of a control write are dropped
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			en_r     <= `MSC_EN_RST;
			lvl_r    <= 2'h0;
			pause_r  <= 1'b0;
			dir_en_r <= 1'b0;
			range_r  <= `MSC_RANGE_RST;
			mask_r   <= '0;
		end else begin
			if (wr_en) begin
				en_r <= bus.wdata;
			end
			if (wr_ctrl) begin
				lvl_r    <= bus.wdata[`MSC_B_LVL_HI:`MSC_B_LVL_LO];
				pause_r  <= bus.wdata[`MSC_B_PAUSE];
				dir_en_r <= bus.wdata[`MSC_B_DIR_EN];
			end
			if (wr_range) begin
				range_r <= bus.wdata[`MSC_RANGE_W-1:0];
			end
			if (wr_mask) begin
				mask_r <= bus.wdata[`MSC_IRQ_W-1:0];
			end
		end
	end

	// One-word sample buffer keeps filling even while paused
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			buf_r <= '0;
		end else if (conv) begin
			buf_r <= sample.data;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sts_r      <= '0;
			irq_r      <= 1'b0;
			stable_q_r <= 1'b0;
		end else begin
			sts_r      <= sts_nxt;
			irq_r      <= |(sts_nxt & mask_r);
			stable_q_r <= stable;
		end
	end

	// Read path, data stands one cycle after the strobe
	wire logic [`MSC_DW-1:0] ctrl_rd = {lvl_r, ack_r, pause_r, dir_en_r, dir_r, det_r, stable};
	wire logic [`MSC_DW-1:0] rd_mux =
		msc_hit(bus.addr, `MSC_OFF_ENABLE)   ? en_r :
		msc_hit(bus.addr, `MSC_OFF_CTRL)     ? ctrl_rd :
		msc_hit(bus.addr, `MSC_OFF_RANGE)    ? {5'h00, range_r} :
		msc_hit(bus.addr, `MSC_OFF_IRQ_STS)  ? {5'h00, sts_r} :
		msc_hit(bus.addr, `MSC_OFF_IRQ_MASK) ? {5'h00, mask_r} : 8'h00;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= bus.rd ? rd_mux : 8'h00;
		end
	end

	assign rdata = rdata_r;
	assign irq   = irq_r;

	a_ack_on_stop: assert property (@(posedge clock) disable iff (!rst_n)
		(running && sample.valid && en_r == `MSC_OFF_CODE && !bus.wr) |=> (ack_r && state_r == MSC_ST_OFF))
		else $error("acknowledge not set after off code");

	a_ack_clear_init: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == MSC_ST_INIT && sample.valid && en_r == `MSC_ON_CODE && !bus.wr) |=> (!ack_r && running))
		else $error("acknowledge not cleared on first conversion");

	a_off_idle: assert property (@(posedge clock) disable iff (!rst_n)
		(state_r == MSC_ST_OFF && !on_wr) |=> ($stable(det_r) || !det_r) && $stable(buf_r))
		else $error("engine processed while off");

	a_pause_no_det: assert property (@(posedge clock) disable iff (!rst_n)
		(pause_r && !det_r && !on_wr) |=> !det_r)
		else $error("detection while paused");

	a_resume_det: assert property (@(posedge clock) disable iff (!rst_n)
		(running && sample.valid && !pause_r && stable && mag > thr && en_r != `MSC_OFF_CODE && !bus.wr)
		|=> det_r)
		else $error("detection missed after resume");

	a_det_sticky: assert property (@(posedge clock) disable iff (!rst_n)
		(det_r && !det_clr && !on_wr) |=> det_r)
		else $error("detected flag lost without software clear");

	a_dir_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(det_r && !det_clr && !on_wr) |=> $stable(dir_r))
		else $error("direction changed while detected flag set");

	a_dir_mode_off: assert property (@(posedge clock) disable iff (!rst_n)
		(det_set && !det_r && !dir_en_r && !on_wr) |=> !dir_r)
		else $error("direction reported in standard mode");

	a_unstable_mute: assert property (@(posedge clock) disable iff (!rst_n)
		(!stable && !det_r && !on_wr) |=> !det_r)
		else $error("detection while offset not settled");

	a_restart_stable: assert property (@(posedge clock) disable iff (!rst_n)
		(on_wr || wake) |=> !stable ##1 !stable)
		else $error("stable flag kept across restart");

	a_ro_ignored: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_ctrl && !sample.valid) |=> ($stable(ack_r) && $stable(dir_r)))
		else $error("engine-owned bit changed by write");

	// Buffer keeps taking conversions while detection is paused
	a_pause_buffer: assert property (@(posedge clock) disable iff (!rst_n)
		(pause_r && conv) |=> (buf_r == $past(sample.data)))
		else $error("sample not buffered while paused");

	a_dir_latch: assert property (@(posedge clock) disable iff (!rst_n)
		(det_set && !det_r && dir_en_r && !on_wr) |=> (dir_r == $past(pos)))
		else $error("direction not latched at detection");

	a_on_clears: assert property (@(posedge clock) disable iff (!rst_n)
		on_wr |=> (!det_r && !dir_r && !stable && state_r == MSC_ST_INIT))
		else $error("engine flags not defaulted on enable");

	a_det_event: assert property (@(posedge clock) disable iff (!rst_n)
		(det_set && !on_wr) |=> (det_r && sts_r[`MSC_IRQ_DET]))
		else $error("detection not recorded");

	a_stop_event: assert property (@(posedge clock) disable iff (!rst_n)
		stop_seen |=> sts_r[`MSC_IRQ_STOP])
		else $error("engine stop not recorded");

	a_reserved_ign: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_en && bus.wdata != `MSC_ON_CODE && bus.wdata != `MSC_OFF_CODE && !sample.valid)
		|=> ($stable(state_r) && $stable(ack_r)))
		else $error("reserved enable code changed engine state");

endmodule : msc_engine

`default_nettype wire

//--- test/msc_sensor_model.sv
// Purpose: infrared sensor behind its converter, one conversion every PERIOD cycles
// Assumes: the bench sets the deviation from the rest level of 200h
// Notes:   data lines toggle between conversions so stale values never pass for fresh ones
`default_nettype none
module msc_sensor_model
	import msc_pkg::*;
#(
	parameter int PERIOD = 8
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic signed [9:0] dev,
	output var  msc_sample_t       sample
);
	timeunit 1ns;
	timeprecision 1ns;
	int  cnt_r;
	wire conv = rst_n && cnt_r == PERIOD - 1;
	always_ff @(posedge clock) begin
		cnt_r        <= (!rst_n || conv) ? 0 : cnt_r + 1;
		sample.valid <= conv;
		sample.data  <= !rst_n ? 10'h155 : conv ? 10'h200 + dev : ~sample.data;
	end
endmodule : msc_sensor_model
`default_nettype wire

//--- test/testbench.sv
// Purpose: self-checking bench of the motion status/control register bank
// Assumes: sensor model converts every 8 cycles, offset settling shortened to 4 samples
// Notes:   reset values and settling first, then threshold rows, flag ownership, pause, off/on, wake and reset cases
`default_nettype none
`include "msc_defs.svh"
module testbench
	import msc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [1:0] lvl;
		logic [2:0] rng;
		logic [9:0] dev;
		logic       det;
		logic       dir;
	} msc_row_t;
	logic              clock = 1'h0;
	logic              rst_n = 1'h0;
	msc_bus_req_t      bus   = '0;
	logic              wake  = 1'h0;
	logic signed [9:0] dev   = '0;
	logic [7:0]        rdata;
	logic              irq;
	msc_sample_t       sample;
	logic [7:0]        got;
	logic [7:0]        exp;
	int                n_errors  = 0;
	int                cmp_count = 0;
	logic [11:0]       ra [6] = '{12'h100, 12'h102, 12'h104, 12'h110, 12'h111, 12'h1FF};
	logic [7:0]        re [6] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
	msc_row_t          rows [8] = '{
		'{2'h0, 3'h7, 10'h06F, 1'h0, 1'h0},
		'{2'h0, 3'h7, 10'h081, 1'h1, 1'h1},
		'{2'h0, 3'h0, 10'h39C, 1'h1, 1'h0},
		'{2'h1, 3'h7, 10'h3CD, 1'h0, 1'h0},
		'{2'h1, 3'h7, 10'h3BB, 1'h1, 1'h0},
		'{2'h2, 3'h7, 10'h027, 1'h1, 1'h1},
		'{2'h3, 3'h7, 10'h006, 1'h0, 1'h0},
		'{2'h3, 3'h0, 10'h3EC, 1'h1, 1'h0}};

	always #50 clock = ~clock;

	msc_sensor_model #(.PERIOD(8)) sensor (.clock(clock), .rst_n(rst_n), .dev(dev), .sample(sample));
	msc_engine #(.TRK_COUNT(4)) uut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.sample(sample), .wake(wake), .irq(irq));

	task automatic check(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check

	task automatic wrap_up();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus <= '{1'h1, 1'h0, a, d};
		@(posedge clock);
		bus <= '0;
		@(posedge clock);
	endtask : wr

	task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
		bus <= '{1'h0, 1'h1, a, 8'h00};
		@(posedge clock);
		bus <= '0;
		@(negedge clock);
		got = rdata;
		check(got & m, e & m);
		@(posedge clock);
	endtask : rc

	task automatic irq_is(input logic e);
		@(negedge clock);
		check({7'h00, irq}, {7'h00, e});
		@(posedge clock);
	endtask : irq_is

	// Returns just after the edge at which the engine takes a conversion
	task automatic smp(input int n);
		repeat (n) begin
			@(posedge clock);
			while (sample.valid !== 1'h1) @(posedge clock);
		end
	endtask : smp

	// Exactly one conversion carries the deviation
	task automatic pulse(input logic [9:0] d);
		smp(1);
		dev <= d;
		smp(1);
		dev <= '0;
		repeat (2) @(posedge clock);
	endtask : pulse

	initial begin
		#500000;
		n_errors++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		wr(12'h1FF, 8'hAA);
		foreach (ra[i]) rc(ra[i], re[i], 8'hFF);
		wr(`MSC_OFF_IRQ_MASK, 8'h07);
		wr(`MSC_OFF_ENABLE, `MSC_ON_CODE);
		smp(1);
		rc(`MSC_OFF_CTRL, 8'h00, 8'hFF);
		smp(3);
		rc(`MSC_OFF_CTRL, 8'h00, 8'hFF);
		smp(1);
		rc(`MSC_OFF_CTRL, 8'h01, 8'hFF);
		irq_is(1'h1);
		rc(`MSC_OFF_IRQ_STS, 8'h02, 8'hFF);
		wr(`MSC_OFF_IRQ_STS, 8'h02);
		irq_is(1'h0);
		foreach (rows[i]) begin
			wr(`MSC_OFF_RANGE, {5'h00, rows[i].rng});
			wr(`MSC_OFF_CTRL, {rows[i].lvl, 6'h08});
			pulse(rows[i].dev);
			exp = {rows[i].lvl, 3'h1, rows[i].dir, rows[i].det, 1'h1};
			rc(`MSC_OFF_CTRL, exp, rows[i].det ? 8'hFF : 8'hFB);
		end
		wr(`MSC_OFF_CTRL, 8'hEF);
		pulse(10'h014);
		rc(`MSC_OFF_CTRL, 8'hCB, 8'hFF);
		wr(`MSC_OFF_IRQ_MASK, 8'h00);
		irq_is(1'h0);
		wr(`MSC_OFF_IRQ_MASK, 8'h01);
		irq_is(1'h1);
		wr(`MSC_OFF_IRQ_STS, 8'hFF);
		irq_is(1'h0);
		wr(`MSC_OFF_CTRL, 8'hD8);
		pulse(10'h3EC);
		rc(`MSC_OFF_CTRL, 8'hD9, 8'hFB);
		wr(`MSC_OFF_CTRL, 8'hC8);
		pulse(10'h3EC);
		rc(`MSC_OFF_CTRL, 8'hCB, 8'hFF);
		wr(`MSC_OFF_CTRL, 8'hC0);
		pulse(10'h014);
		rc(`MSC_OFF_CTRL, 8'hC3, 8'hFF);
		wr(`MSC_OFF_ENABLE, 8'h55);
		smp(1);
		rc(`MSC_OFF_ENABLE, 8'h55, 8'hFF);
		rc(`MSC_OFF_CTRL, 8'h00, 8'h20);
		wr(`MSC_OFF_ENABLE, `MSC_OFF_CODE);
		rc(`MSC_OFF_CTRL, 8'h00, 8'h20);
		smp(1);
		rc(`MSC_OFF_CTRL, 8'h20, 8'h20);
		rc(`MSC_OFF_IRQ_STS, 8'h04, 8'h04);
		wr(`MSC_OFF_CTRL, 8'hC0);
		pulse(10'h014);
		rc(`MSC_OFF_CTRL, 8'h00, 8'h02);
		wr(`MSC_OFF_ENABLE, `MSC_ON_CODE);
		smp(1);
		rc(`MSC_OFF_CTRL, 8'hC0, 8'hFF);
		smp(4);
		rc(`MSC_OFF_CTRL, 8'hC1, 8'hFF);
		wake <= 1'h1;
		@(posedge clock);
		wake <= 1'h0;
		smp(1);
		rc(`MSC_OFF_CTRL, 8'hC0, 8'hFF);
		wr(`MSC_OFF_CTRL, 8'hE7);
		pulse(10'h0C8);
		rc(`MSC_OFF_CTRL, 8'hC0, 8'hFF);
		rst_n <= 1'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		rc(`MSC_OFF_CTRL, 8'h20, 8'hFF);
		irq_is(1'h0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
